/* dtfr_defs.vh */
// constants for the device transport frame receive block
`ifndef DTFR_DEFS_VH
`define DTFR_DEFS_VH

// frame type codes seen in the first dword, low byte
`define DTFR_TYPE_REG_H2D   8'h27
`define DTFR_TYPE_DATA_H2D  8'h46

// register frame length in dwords
`define DTFR_REG_DWORDS     3'h5

// one-hot state codes
`define DTFR_ST_IDLE        5'h01
`define DTFR_ST_REG         5'h02
`define DTFR_ST_DPREP       5'h04
`define DTFR_ST_DREC        5'h08
`define DTFR_ST_DABORT      5'h10

// shadow register reset value
`define DTFR_SHADOW_RST     32'h00000000

`endif

/* dtfr_link_model.sv */
// link layer model feeding frames, plus the application abort line
`timescale 1ns/1ps
`default_nettype none
module dtfr_link_model (
  input wire logic        clk_sys,
  input wire logic        lnk_continue,
  output var logic        lnk_sof,
  output var logic        lnk_valid,
  output var logic [31:0] lnk_data,
  output var logic        lnk_eof,
  output var logic        lnk_crc_err,
  output var logic        lnk_illegal,
  output var logic        app_abort_req
);
  // quiet lines at start; data toggles on stalled beats, and after a frame is inverted once and then held
  initial {lnk_sof, lnk_valid, lnk_data, lnk_eof, lnk_crc_err, lnk_illegal, app_abort_req} = '0;
  // head dword then n payload dwords; data frames wait on continue
  task automatic send(input logic [7:0] ty, input int n, input logic err, input logic ill,
                      input int ab);
    int k;
    k = 0;
    @(negedge clk_sys);
    // error and illegal frames carry their own head and payload values
    {lnk_sof, lnk_valid, lnk_data} = {2'b11, 6'h29, err, ill, 16'hC3E1, ty};
    while (k < n)
    begin
      @(negedge clk_sys);
      lnk_sof = 1'b0;
      lnk_valid = ty != 8'h46 || lnk_continue;
      app_abort_req = lnk_valid && k == ab;
      lnk_data = lnk_valid ? 32'h0000_0100 + k + {err, ill, 12'h000} : ~lnk_data;
      k = k + lnk_valid;
      lnk_eof = lnk_valid && k == n && !ill;
      lnk_illegal = lnk_valid && k == n && ill;
      lnk_crc_err = err;
    end
    @(negedge clk_sys);
    {lnk_valid, lnk_eof, lnk_illegal, lnk_crc_err, app_abort_req} = '0;
    lnk_data = ~lnk_data;
  endtask
endmodule
`default_nettype wire

/* dtfr_receive.v */
// device transport receive logic for register and data host-to-device frames
`timescale 1ns/1ps
`default_nettype none
`include "dtfr_defs.vh"
// Notes on behaviour
// - register frames are never throttled; every dword is taken at the link pace.
// - shadow registers load from the captured frame only when it ends error-free.
// - good register frame pulses command-arrived to the application, then idle.
// - errored register frame pulses error status to link, idle, no command pulse.
// - link illegal-transition notice drops every receive state back to idle.
// - data frame enters a prepare state, then data-receive once the fifo can accept.
// - in data-receive each dword is written to the fifo and link told to continue.
// - data-receive holds until the link gives end of frame.
// - end of data frame in normal reception returns to idle.
// - application abort request during data-receive moves to the abort state.
// - abort state signals link abort, returns to data-receive if not yet complete.
// - abort coinciding with end of transfer still signals abort, then goes idle.

module dtfr_receive
#(
  parameter DW = 32
)
(
  input  wire          clk_sys,
  input  wire          rst_n,
  // link layer side
  input  wire          lnk_sof,
  input  wire          lnk_valid,
  input  wire [DW-1:0] lnk_data,
  input  wire          lnk_eof,
  input  wire          lnk_crc_err,
  input  wire          lnk_illegal,
  output wire          lnk_continue,
  output reg           lnk_abort,
  output reg           lnk_err_status,
  // data fifo write side
  output reg           fifo_wr_en,
  output reg  [DW-1:0] fifo_wr_data,
  input  wire          fifo_ready,
  // application layer side
  input  wire          app_abort_req,
  output reg           app_cmd_rcvd,
  output reg  [DW-1:0] shadow_dw0,
  output reg  [DW-1:0] shadow_dw1,
  output reg  [DW-1:0] shadow_dw2,
  output reg  [DW-1:0] shadow_dw3,
  output reg  [DW-1:0] shadow_dw4,
  output wire          rx_busy
);

  // one-hot state codes; the default branch sends any stray code back to idle
  localparam [4:0] ST_IDLE   = `DTFR_ST_IDLE;
  localparam [4:0] ST_REG    = `DTFR_ST_REG;
  localparam [4:0] ST_DPREP  = `DTFR_ST_DPREP;
  localparam [4:0] ST_DREC   = `DTFR_ST_DREC;
  localparam [4:0] ST_DABORT = `DTFR_ST_DABORT;

  // receive state, beat count and the private copy of a register frame
  reg [4:0]    state_q;
  reg [4:0]    state_d;
  reg [2:0]    cnt_q;
  reg [DW-1:0] cap0_q;
  reg [DW-1:0] cap1_q;
  reg [DW-1:0] cap2_q;
  reg [DW-1:0] cap3_q;
  reg [DW-1:0] cap4_q;
  reg [2:0]    cnt_d;
  reg [DW-1:0] cap1_d;
  reg [DW-1:0] cap2_d;
  reg [DW-1:0] cap3_d;
  reg [DW-1:0] cap4_d;

  // decoded beats and frame types
  wire [7:0] frame_type;
  wire       dword_in;
  wire       is_reg;
  wire       is_data;
  wire       reg_beat;
  wire       reg_end;
  wire       data_beat;
  wire       abort_go;

  // ************************************************************
  // helpers
  // ************************************************************
  // compares the type byte of a head dword against one frame type code;
  // only meaningful while sof flags the head beat
  function type_hit;
    input [7:0] ty;
    input [7:0] code;
    begin
      type_hit = (ty == code);
    end
  endfunction

  // ************************************************************
  // frame decode
  // ************************************************************
  // type sits in the low byte of the first dword, flagged by sof
  assign frame_type = lnk_data[7:0];
  assign dword_in   = lnk_valid & lnk_sof;
  assign is_reg     = dword_in & type_hit(frame_type, `DTFR_TYPE_REG_H2D);
  assign is_data    = dword_in & type_hit(frame_type, `DTFR_TYPE_DATA_H2D);

  // busy covers the whole life of a frame, prepare and abort included
  assign rx_busy    = (state_q != ST_IDLE);

  // beats that the receive paths act on; an illegal notice voids the beat
  assign reg_beat  = (state_q == ST_REG) & lnk_valid & ~lnk_illegal;
  assign reg_end   = (state_q == ST_REG) & lnk_eof & ~lnk_illegal;
  assign data_beat = ((state_q == ST_DREC) | (state_q == ST_DABORT)) & lnk_valid & fifo_ready
                     & ~lnk_illegal;
  // abort is raised only from data-receive, with or without a coinciding eof
  assign abort_go  = (state_q == ST_DREC) & app_abort_req & ~lnk_illegal;

  // link continues only in data-receive; stalls on a full fifo and in the abort state
  assign lnk_continue = (state_q == ST_DREC) & fifo_ready;

  // ************************************************************
  // next-state logic
  // ************************************************************
  // illegal-transition checked first so it beats every other exit
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (is_reg)
          state_d = ST_REG;
        else if (is_data)
          state_d = ST_DPREP;
      end
      ST_REG:
      begin
        if (lnk_illegal)
          state_d = ST_IDLE;
        else if (lnk_eof)
          state_d = ST_IDLE;
      end
      ST_DPREP:
      begin
        if (lnk_illegal)
          state_d = ST_IDLE;
        else if (fifo_ready)
          state_d = ST_DREC;
      end
      ST_DREC:
      begin
        if (lnk_illegal)
          state_d = ST_IDLE;
        else if (lnk_eof)
          state_d = ST_IDLE;
        else if (app_abort_req)
          state_d = ST_DABORT;
        else
          state_d = ST_DREC;
      end
      ST_DABORT:
      begin
        if (lnk_illegal)
          state_d = ST_IDLE;
        else if (lnk_eof)
          state_d = ST_IDLE;
        else
          state_d = ST_DREC;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  // one register holds the whole receive state, one-hot
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // ************************************************************
  // register frame capture
  // ************************************************************
  // next capture values are formed here so that a dword arriving together
  // with eof is part of the commit; a copy taken from the flops would lag a beat
  always @*
  begin
    cnt_d  = cnt_q;
    cap1_d = cap1_q;
    cap2_d = cap2_q;
    cap3_d = cap3_q;
    cap4_d = cap4_q;
    if (state_q == ST_IDLE && is_reg)
      cnt_d = 3'h1;
    else if (reg_beat)
    begin
      // the beat count picks the slot; the head dword went to slot 0
      case (cnt_q)
        3'h1:    cap1_d = lnk_data;
        3'h2:    cap2_d = lnk_data;
        3'h3:    cap3_d = lnk_data;
        3'h4:    cap4_d = lnk_data;
        default: cap4_d = cap4_q; // dwords past the fifth are dropped
      endcase
      if (cnt_q != `DTFR_REG_DWORDS)
        cnt_d = cnt_q + 3'h1;
    end
  end

  // capture stays private until a clean end, so the shadows never see a torn frame;
  // register frames are taken at the link pace and never stalled
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cnt_q  <= 3'h0;
      cap0_q <= `DTFR_SHADOW_RST;
      cap1_q <= `DTFR_SHADOW_RST;
      cap2_q <= `DTFR_SHADOW_RST;
      cap3_q <= `DTFR_SHADOW_RST;
      cap4_q <= `DTFR_SHADOW_RST;
    end
    else
    begin
      cnt_q  <= cnt_d;
      cap1_q <= cap1_d;
      cap2_q <= cap2_d;
      cap3_q <= cap3_d;
      cap4_q <= cap4_d;
      if (state_q == ST_IDLE && is_reg)
        cap0_q <= lnk_data;
    end
  end

  // ************************************************************
  // shadow commit and register frame status
  // ************************************************************
  // a good end loads all five dwords at once; an errored or dropped frame
  // leaves the shadows alone; only an errored one pulses the error status, a dropped one pulses nothing
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      shadow_dw0     <= `DTFR_SHADOW_RST;
      shadow_dw1     <= `DTFR_SHADOW_RST;
      shadow_dw2     <= `DTFR_SHADOW_RST;
      shadow_dw3     <= `DTFR_SHADOW_RST;
      shadow_dw4     <= `DTFR_SHADOW_RST;
      app_cmd_rcvd   <= 1'b0;
      lnk_err_status <= 1'b0;
    end
    else
    begin
      app_cmd_rcvd   <= 1'b0;
      lnk_err_status <= 1'b0;
      if (reg_end && !lnk_crc_err)
      begin
        shadow_dw0   <= cap0_q;
        shadow_dw1   <= cap1_d;
        shadow_dw2   <= cap2_d;
        shadow_dw3   <= cap3_d;
        shadow_dw4   <= cap4_d;
        app_cmd_rcvd <= 1'b1;
      end
      if (reg_end && lnk_crc_err)
        lnk_err_status <= 1'b1;
    end
  end

  // ************************************************************
  // data fifo writes and abort
  // ************************************************************
  // the strobe is registered with its data; a full fifo also drops continue,
  // so a well-behaved link never offers a dword that would be lost here
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      fifo_wr_en   <= 1'b0;
      fifo_wr_data <= {DW{1'b0}};
    end
    else
    begin
      // strobe and data leave together one cycle after the beat
      fifo_wr_en <= data_beat;
      if (data_beat)
        fifo_wr_data <= lnk_data;
    end
  end

  // abort pulse stands during the abort state, or alongside the return to idle
  // when the request meets eof; a held request repeats it on every pass
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      lnk_abort <= 1'b0;
    else
      lnk_abort <= abort_go;
  end

endmodule
`default_nettype wire

/* dtfr_receive_bench.sv */
// self-checking bench for the frame receive block
`timescale 1ns/1ps
`default_nettype none
module dtfr_receive_bench;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        fifo_ready = 1'b1;
  logic        lnk_sof, lnk_valid, lnk_eof, lnk_crc_err, lnk_illegal, app_abort_req, rx_busy;
  logic        lnk_continue, lnk_abort, lnk_err_status, fifo_wr_en, app_cmd_rcvd;
  logic [31:0] lnk_data, fifo_wr_data, shadow_dw0, shadow_dw1, shadow_dw2, shadow_dw3, shadow_dw4;
  int          errors = 0;
  int          checks = 0;
  int          n_cmd, n_err, n_abt, n_wr;
  always #5 clk_sys = ~clk_sys;
  dtfr_receive i_dut (.clk_sys, .rst_n, .lnk_sof, .lnk_valid, .lnk_data, .lnk_eof, .lnk_crc_err,
    .lnk_illegal, .lnk_continue, .lnk_abort, .lnk_err_status, .fifo_wr_en, .fifo_wr_data,
    .fifo_ready, .app_abort_req, .app_cmd_rcvd, .shadow_dw0, .shadow_dw1, .shadow_dw2,
    .shadow_dw3, .shadow_dw4, .rx_busy);
  dtfr_link_model i_link (.clk_sys, .lnk_continue, .lnk_sof, .lnk_valid, .lnk_data, .lnk_eof,
    .lnk_crc_err, .lnk_illegal, .app_abort_req);
  // ************
  // event counts
  // ************
  // pulses last one cycle, so counting every edge catches each one
  always @(posedge clk_sys)
  begin
    n_cmd += app_cmd_rcvd;
    n_err += lnk_err_status;
    n_abt += lnk_abort;
    n_wr += fifo_wr_en;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one frame, then three cycles: every answer comes one cycle after eof
  task automatic run(input logic [7:0] ty, input int n, input logic err, input logic ill,
                     input int ab);
    {n_cmd, n_err, n_abt, n_wr} = '0;
    i_link.send(ty, n, err, ill, ab);
    repeat (3) @(negedge clk_sys);
    check("busy", rx_busy, 1'b0);
  endtask
  // last dword arrives with eof, so shadow4 proves it joins the commit
  task automatic t_reg_good;
    run(8'h27, 4, 1'b0, 1'b0, -1);
    check("cmd", n_cmd, 1);
    check("shadow0", shadow_dw0, {24'hA4C3E1, 8'h27});
    check("shadow1", shadow_dw1, 32'h0000_0100);
    check("shadow2", shadow_dw2, 32'h0000_0101);
    check("shadow3", shadow_dw3, 32'h0000_0102);
    check("shadow4", shadow_dw4, 32'h0000_0103);
  endtask
  // errored and dropped frames carry other data, which must not reach the shadows
  task automatic t_reg_err;
    run(8'h27, 4, 1'b1, 1'b0, -1);
    check("err", n_err, 1);
    check("cmd", n_cmd, 0);
    check("shadow0", shadow_dw0, {24'hA4C3E1, 8'h27});
    check("shadow4", shadow_dw4, 32'h0000_0103);
  endtask
  task automatic t_reg_ill;
    run(8'h27, 4, 1'b0, 1'b1, -1);
    check("cmd", n_cmd + n_err, 0);
    check("shadow1", shadow_dw1, 32'h0000_0100);
    check("shadow4", shadow_dw4, 32'h0000_0103);
  endtask
  // fifo not ready at first, so prepare must hold off
  task automatic t_data;
    fifo_ready = 1'b0;
    fork
      run(8'h46, 6, 1'b0, 1'b0, -1);
      begin
        #30 check("hold", lnk_continue, 1'b0);
        #10 fifo_ready = 1'b1;
        #20 check("continue", lnk_continue, 1'b1);
      end
    join
    check("writes", n_wr, 6);
    check("last", fifo_wr_data, 32'h0000_0105);
  endtask
  task automatic t_abort;
    run(8'h46, 4, 1'b0, 1'b0, 1);
    check("abort", n_abt, 1);
    check("writes", n_wr, 4);
  endtask
  task automatic t_abort_eof;
    run(8'h46, 4, 1'b0, 1'b0, 3);
    check("abort", n_abt, 1);
    check("writes", n_wr, 4);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // the whole run is under a hundred cycles; 2000 means a hang
  initial
  begin
    #20000;
    errors++;
    tally_and_finish;
  end
  initial
  begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reg_good;
    t_reg_err;
    t_reg_ill;
    t_data;
    t_abort;
    t_abort_eof;
    run(8'h46, 4, 1'b0, 1'b1, -1);
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* dtfr_receive_properties.sv */
// assertions on the frame receive block ports
`timescale 1ns/1ps
`default_nettype none
module dtfr_receive_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        lnk_valid,
  input wire logic        lnk_eof,
  input wire logic        lnk_illegal,
  input wire logic        lnk_continue,
  input wire logic        lnk_abort,
  input wire logic        fifo_wr_en,
  input wire logic        app_abort_req,
  input wire logic        app_cmd_rcvd,
  input wire logic        rx_busy,
  input wire logic [31:0] shadow_dw0
);
  // one clock domain, so one default clock and reset for all
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_cmd_idle: assert property (app_cmd_rcvd |-> !rx_busy)
    else $error("command pulse while busy");
  chk_shadow_keep: assert property (!app_cmd_rcvd |-> $stable(shadow_dw0))
    else $error("shadow changed without command");
  chk_ill_drop: assert property (rx_busy && lnk_illegal |=> !rx_busy && !app_cmd_rcvd)
    else $error("illegal notice not obeyed");
  chk_wr_cause: assert property (fifo_wr_en |-> $past(lnk_valid && rx_busy))
    else $error("write without dword");
  chk_eof_idle: assert property (lnk_continue && lnk_eof && !lnk_illegal |=> !rx_busy)
    else $error("eof did not end frame");
  chk_abort_cause: assert property (lnk_abort |-> $past(app_abort_req))
    else $error("abort without request");
  chk_abort_resume: assert property
    (lnk_continue && app_abort_req && !lnk_eof && !lnk_illegal
     |=> lnk_abort ##1 (rx_busy || $past(lnk_eof || lnk_illegal)))
    else $error("abort did not resume");
  chk_abort_eof: assert property
    (lnk_continue && app_abort_req && lnk_eof && !lnk_illegal |=> lnk_abort && !rx_busy)
    else $error("abort at eof not idle");
endmodule
bind dtfr_receive dtfr_receive_chk i_chk (.clk_sys, .rst_n, .lnk_valid, .lnk_eof, .lnk_illegal,
  .lnk_continue, .lnk_abort, .fifo_wr_en, .app_abort_req, .app_cmd_rcvd, .rx_busy, .shadow_dw0);
`default_nettype wire
